// >>> src/atsc_clkgen.v
/*
 * Internal serial clock generator: toggles the clock on each source
 * tick while a transfer runs, parks it high otherwise.
 * Assumes the tick is a one-cycle pulse from the system clock domain.
 */
`timescale 1ns/1ps
`include "atsc_consts.vh"

module atsc_clkgen (
    // Clock and reset
    input wire sys_clk_in,
    input wire rst_in,
    // Control
    input wire run_in,
    input wire tick_in,
    // Serial clock and its edges
    output reg sck_out,
    output reg fall_out,
    output reg rise_out
);

// Clock idles high so a stopped clock is a legal start condition
always @(posedge sys_clk_in)
begin
    if (rst_in)
    begin
        sck_out <= 1'b1;
        fall_out <= 1'b0;
        rise_out <= 1'b0;
    end
    else
    begin
        fall_out <= run_in & tick_in & sck_out;
        rise_out <= run_in & tick_in & ~sck_out;
        if (!run_in)
            sck_out <= 1'b1;
        else if (tick_in)
            sck_out <= ~sck_out;
    end
end

endmodule // atsc_clkgen

// >>> src/atsc_consts.vh
/*
 * Constants of the addressed two-wire serial channel: register offsets,
 * field positions, reset values and bit counts.
 * Assumes inclusion by the channel's modules only; definitions only.
 */
`ifndef ATSC_CONSTS_VH
`define ATSC_CONSTS_VH

// Register offsets on the plain register port
`define ATSC_ADDR_W 3
`define ATSC_OFF_MODE 3'h0
`define ATSC_OFF_SHIFT 3'h1
`define ATSC_OFF_SVA 3'h2
`define ATSC_OFF_BUSCTL 3'h3
`define ATSC_OFF_STATUS 3'h4

// Mode register fields
`define ATSC_MB_CLK_LO 0
`define ATSC_MB_CLK_HI 1
`define ATSC_MB_B2 2
`define ATSC_MB_B3 3
`define ATSC_MB_B4 4
`define ATSC_MB_WUP 5
`define ATSC_MB_COI 6
`define ATSC_MB_CE 7
`define ATSC_MODE_RST 8'h00
`define ATSC_MODE_WMASK 8'hbf

// Bus control register fields
`define ATSC_BB_RELEASE_TRIGGER 0
`define ATSC_BB_CMDT 1
`define ATSC_BB_RELEASE_DETECTED 2
`define ATSC_BB_COMMAND_DETECTED 3
`define ATSC_BB_BSYE 7

// Status register fields
`define ATSC_SB_DONE 0
`define ATSC_SB_BUSY 1

// Clock counts of one transfer and the shift register reset value
`define ATSC_BITS_DATA 4'h8
`define ATSC_BITS_SBI 4'h9
`define ATSC_SHIFT_RST 8'hff

`endif

// >>> src/atsc_sync.v
/*
 * Two-flop synchroniser with edge detection for pins from outside
 * the system clock domain. One entry per bit.
 * Assumes pins are asynchronous; first flop feeds only the second.
 */
`timescale 1ns/1ps
`include "atsc_consts.vh"

module atsc_sync #(
    parameter W = 3
) (
    // Clock and reset
    input wire sys_clk_in,
    input wire rst_in,
    // Raw pins
    input wire [W-1:0] pin_in,
    // Synchronised level and edges
    output wire [W-1:0] lvl_out,
    output wire [W-1:0] rise_out,
    output wire [W-1:0] fall_out
);

genvar i;
generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
        reg meta_r;
        reg sync_r;
        reg prev_r;
        // Pins idle high (pull-ups), so reset to high
        always @(posedge sys_clk_in)
        begin
            if (rst_in)
            begin
                meta_r <= 1'b1;
                sync_r <= 1'b1;
                prev_r <= 1'b1;
            end
            else
            begin
                meta_r <= pin_in[i];
                sync_r <= meta_r;
                prev_r <= sync_r;
            end
        end
        assign lvl_out[i] = sync_r;
        assign rise_out[i] = sync_r & ~prev_r;
        assign fall_out[i] = ~sync_r & prev_r;
    end
endgenerate

endmodule // atsc_sync

// >>> src/atsc_top.v
/*
 * Serial channel 0 in addressed bus mode and 2-wire mode: shift
 * register, transfer sequencing, busy, bus release/command detection,
 * slave address compare and done flag, with a plain register port.
 * Assumes an external pull-up on the data lines; ticks of timer 2 and
 * of the timer clock select come from the system clock domain.
 */
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "atsc_consts.vh"

module atsc_top (
    // Clock and reset
    input wire sys_clk_in,
    input wire rst_in,
    // Register port
    input wire [`ATSC_ADDR_W-1:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [7:0] reg_rdata_out,
    // Internal clock sources
    input wire timer2_tick_in,
    input wire timer_clk_sel3_tick_in,
    // Serial clock pin
    input wire bus_clock_pin_in,
    output wire bus_clock_pin_out,
    output reg bus_clock_pin_oe_n_out,
    // Data line a (open drain)
    input wire bus_data_a_in,
    output reg bus_data_a_out,
    output reg bus_data_a_oe_n_out,
    // Data line b (open drain)
    input wire bus_data_b_in,
    output reg bus_data_b_out,
    output reg bus_data_b_oe_n_out,
    // Events
    output reg transfer_done_flag_out,
    output reg address_match_irq_out
);

// Transfer states
localparam ST_IDLE = 3'b001;
localparam ST_WAIT = 3'b010;
localparam ST_SHIFT = 3'b100;

reg [7:0] mode_r;
reg [7:0] shift_r;
reg [7:0] sva_r;
reg [2:0] state_r;
reg [3:0] cnt_r;
reg so_latch_r;
reg busy_en_r;
reg busy_drv_r;
reg release_detected_r;
reg command_detected_r;
reg done_r;
reg [2:0] state_nxt;

wire ce, wake_up_select, sbi_mode, int_clk, use_a;
wire [2:0] pin_lvl, pin_rise, pin_fall;
wire int_sck, int_fall, int_rise, int_tick;
wire sck_lvl, sck_fall, sck_rise;
wire data_lvl, data_rise, data_fall;
wire addr_match;
wire [3:0] last_cnt;
wire wr_mode, wr_shift, wr_sva, wr_busctl, wr_status;
wire start_ok, last_rise, done_set, drv_low;

// Mode decode
assign ce = mode_r[`ATSC_MB_CE];
assign wake_up_select = mode_r[`ATSC_MB_WUP];
// Bit 4 low is 3-wire mode, which this block does not serve
assign sbi_mode = mode_r[`ATSC_MB_B4] & ~mode_r[`ATSC_MB_B3];
assign use_a = mode_r[`ATSC_MB_B2];
assign int_clk = mode_r[`ATSC_MB_CLK_HI];
assign int_tick = mode_r[`ATSC_MB_CLK_LO] ? timer_clk_sel3_tick_in
    : timer2_tick_in;
assign last_cnt = sbi_mode ? `ATSC_BITS_SBI : `ATSC_BITS_DATA;

// Register write decode
assign wr_mode = reg_wr_in & (reg_addr_in == `ATSC_OFF_MODE);
assign wr_shift = reg_wr_in & (reg_addr_in == `ATSC_OFF_SHIFT);
assign wr_sva = reg_wr_in & (reg_addr_in == `ATSC_OFF_SVA);
assign wr_busctl = reg_wr_in & (reg_addr_in == `ATSC_OFF_BUSCTL);
assign wr_status = reg_wr_in & (reg_addr_in == `ATSC_OFF_STATUS);

// Pins: clock, data a, data b
atsc_sync #(
    .W(3)
) u_sync (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .pin_in({bus_data_b_in, bus_data_a_in, bus_clock_pin_in}),
    .lvl_out(pin_lvl),
    .rise_out(pin_rise),
    .fall_out(pin_fall)
);

atsc_clkgen u_clkgen (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .run_in(state_r[2] & int_clk & ce),
    .tick_in(int_tick),
    .sck_out(int_sck),
    .fall_out(int_fall),
    .rise_out(int_rise)
);

assign bus_clock_pin_out = int_sck;

// Serial clock and data seen by the shifter
assign sck_lvl = int_clk ? int_sck : pin_lvl[0];
assign sck_fall = int_clk ? int_fall : pin_fall[0];
assign sck_rise = int_clk ? int_rise : pin_rise[0];
assign data_lvl = use_a ? pin_lvl[1] : pin_lvl[2];
assign data_rise = use_a ? pin_rise[1] : pin_rise[2];
assign data_fall = use_a ? pin_fall[1] : pin_fall[2];

// Comparator reads zero while the channel is stopped
assign addr_match = ce & (sva_r == shift_r);

// Start: clock idle high; in bus mode data line must read ready
assign start_ok = sck_lvl & (~sbi_mode | data_lvl);
assign last_rise = state_r[2] & sck_rise & (cnt_r == last_cnt - 4'h1);
// In bus mode, wake-up suppresses the flag unless release, command and an address match were all seen
assign done_set = last_rise & (~(wake_up_select & sbi_mode)
    | (command_detected_r & release_detected_r & addr_match));

// State sequencing
always @*
begin
    state_nxt = state_r;
    case (state_r)
        ST_IDLE:
        begin
            if (wr_shift & ce)
                state_nxt = ST_WAIT;
        end
        ST_WAIT:
        begin
            if (start_ok)
                state_nxt = ST_SHIFT;
        end
        ST_SHIFT:
        begin
            if (last_rise)
                state_nxt = ST_IDLE;
        end
        default:
        begin
            state_nxt = ST_IDLE;
        end
    endcase
    if (!ce)
        state_nxt = ST_IDLE;
end

// Transfer datapath
always @(posedge sys_clk_in)
begin
    if (rst_in)
    begin
        state_r <= ST_IDLE;
        cnt_r <= 4'h0;
        shift_r <= `ATSC_SHIFT_RST;
        so_latch_r <= 1'b1;
    end
    else
    begin
        state_r <= state_nxt;
        if (state_r[2])
        begin
            if (sck_fall)
                so_latch_r <= (cnt_r < `ATSC_BITS_DATA) ? shift_r[7]
                    : 1'b1;
            if (sck_rise)
            begin
                cnt_r <= cnt_r + 4'h1;
                if (cnt_r < `ATSC_BITS_DATA)
                    shift_r <= {shift_r[6:0], data_lvl};
            end
        end
        else
        begin
            cnt_r <= 4'h0;
            // Data written but not yet started is kept, never lost
            if (wr_shift)
                shift_r <= reg_wdata_in;
            if (wr_busctl & reg_wdata_in[`ATSC_BB_RELEASE_TRIGGER])
                so_latch_r <= 1'b1;
            else if (wr_busctl & reg_wdata_in[`ATSC_BB_CMDT])
                so_latch_r <= 1'b0;
        end
    end
end

// Registers, busy, release and command detection
always @(posedge sys_clk_in)
begin
    if (rst_in)
    begin
        mode_r <= `ATSC_MODE_RST;
        sva_r <= 8'h00;
        busy_en_r <= 1'b0;
        busy_drv_r <= 1'b0;
        release_detected_r <= 1'b0;
        command_detected_r <= 1'b0;
        done_r <= 1'b0;
    end
    else
    begin
        if (wr_mode)
            mode_r <= reg_wdata_in & `ATSC_MODE_WMASK;
        if (wr_sva)
            sva_r <= reg_wdata_in;
        if (wr_busctl)
            busy_en_r <= reg_wdata_in[`ATSC_BB_BSYE];
        // Busy outlives its clear until the next falling clock
        if (last_rise & busy_en_r & sbi_mode)
            busy_drv_r <= 1'b1;
        else if (sck_fall & ~busy_en_r)
            busy_drv_r <= 1'b0;
        // Release: data rises with clock high; command: data falls
        if (sbi_mode & ~state_r[2] & sck_lvl & data_rise)
        begin
            release_detected_r <= 1'b1;
            command_detected_r <= 1'b0;
        end
        else if (sbi_mode & ~state_r[2] & sck_lvl & data_fall)
            command_detected_r <= 1'b1;
        else if (last_rise & wake_up_select & ~addr_match)
            release_detected_r <= 1'b0;
        if (!ce)
        begin
            release_detected_r <= 1'b0;
            command_detected_r <= 1'b0;
        end
        // Set wins over a clear in the same cycle
        if (done_set)
            done_r <= 1'b1;
        else if (wr_status & reg_wdata_in[`ATSC_SB_DONE])
            done_r <= 1'b0;
    end
end

// Open-drain drive: low only for a zero bit, a command trigger or busy
assign drv_low = ce & mode_r[`ATSC_MB_B4]
    & ((~so_latch_r & ~wake_up_select) | busy_drv_r);

// Pin outputs and events
always @(posedge sys_clk_in)
begin
    if (rst_in)
    begin
        bus_data_a_out <= 1'b0;
        bus_data_b_out <= 1'b0;
        bus_data_a_oe_n_out <= 1'b1;
        bus_data_b_oe_n_out <= 1'b1;
        bus_clock_pin_oe_n_out <= 1'b1;
        transfer_done_flag_out <= 1'b0;
        address_match_irq_out <= 1'b0;
    end
    else
    begin
        bus_data_a_out <= 1'b0;
        bus_data_b_out <= 1'b0;
        bus_data_a_oe_n_out <= ~(drv_low & use_a);
        bus_data_b_oe_n_out <= ~(drv_low & ~use_a);
        bus_clock_pin_oe_n_out <= ~(ce & int_clk);
        transfer_done_flag_out <= done_set | (done_r
            & ~(wr_status & reg_wdata_in[`ATSC_SB_DONE]));
        address_match_irq_out <= done_set;
    end
end

// Read port: data stand one cycle after the strobe only
always @(posedge sys_clk_in)
begin
    if (rst_in)
        reg_rdata_out <= 8'h00;
    else if (reg_rd_in)
    begin
        case (reg_addr_in)
            `ATSC_OFF_MODE:
                reg_rdata_out <= {mode_r[7], addr_match,
                    mode_r[5:0]};
            `ATSC_OFF_SHIFT:
                reg_rdata_out <= shift_r;
            `ATSC_OFF_SVA:
                reg_rdata_out <= sva_r;
            `ATSC_OFF_BUSCTL:
                reg_rdata_out <= {busy_en_r, 3'h0, command_detected_r, release_detected_r,
                    2'h0};
            `ATSC_OFF_STATUS:
                reg_rdata_out <= {5'h00, ~state_r[0], busy_drv_r,
                    done_r};
            default:
                reg_rdata_out <= 8'h00;
        endcase
    end
    else
        reg_rdata_out <= 8'h00;
end

endmodule // atsc_top

// >>> testbench/atsc_far_end.sv
/*
 * Far-end model: clock source for external clock mode and an
 * open-drain talker and listener on the chosen data line.
 * Assumes the bench resolves the wired lines with a pull-up.
 */
`timescale 1ns/1ps

module atsc_far_end (
    // Shared lines as seen
    input wire sck_in,
    input wire sda_in,
    // Own drivers
    output logic sck_out,
    output logic sda_low_out
);
    logic [7:0] tx_byte = 8'hff;
    logic [7:0] rx_byte = 8'h00;
    int rises = 0;
    int falls = 0;

    // Idle: clock high, line released
    initial
    begin
        sck_out = 1'b1;
        sda_low_out = 1'b0;
    end
    // Listen on the rising clock, MSB arrives first
    always @(posedge sck_in)
    begin
        rx_byte <= {rx_byte[6:0], sda_in};
        rises <= rises + 1;
    end
    // Talk on the falling clock; open drain can only pull low
    always @(negedge sck_in)
    begin
        sda_low_out <= falls < 8 && !tx_byte[7 - falls];
        falls <= falls + 1;
    end
    // Clock bursts only within a frame; line released once done
    task gen_clock(input int n);
        #7;
        repeat (n)
        begin
            #160 sck_out = 1'b0;
            #160 sck_out = 1'b1;
        end
        #160 sda_low_out = 1'b0;
    endtask
endmodule // atsc_far_end

// >>> testbench/atsc_props.sv
/*
 * Checker of the serial channel top: register port, pins and events.
 * Assumes binding to atsc_top; one clock domain, synchronous reset.
 */
`timescale 1ns/1ps
`include "atsc_consts.vh"

module atsc_props (
    // Clock and reset
    input wire sys_clk_in,
    input wire rst_in,
    // Register port
    input wire [`ATSC_ADDR_W-1:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [7:0] reg_rdata_out,
    // Pins and events
    input wire bus_clock_pin_oe_n_out,
    input wire bus_data_a_out,
    input wire bus_data_a_oe_n_out,
    input wire bus_data_b_out,
    input wire bus_data_b_oe_n_out,
    input wire transfer_done_flag_out,
    input wire address_match_irq_out
);
    reg [7:0] mode_r;
    wire clr_w;
    wire off_w;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    // Shadow of the mode register; bit 6 is never written
    always @(posedge sys_clk_in)
    begin
        if (rst_in)
            mode_r <= 8'h00;
        else if (reg_wr_in && reg_addr_in == `ATSC_OFF_MODE)
            mode_r <= reg_wdata_in & `ATSC_MODE_WMASK;
    end
    // Done clear request and channel-off decode
    assign clr_w = reg_wr_in && reg_addr_in == `ATSC_OFF_STATUS &&
        reg_wdata_in[`ATSC_SB_DONE];
    assign off_w = !mode_r[`ATSC_MB_CE];

    a_rdata_idle: assert property (
        !$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
        else $error("read data outside its slot");
    a_mode_read: assert property (
        $past(reg_rd_in && reg_addr_in == `ATSC_OFF_MODE) |->
        {reg_rdata_out[7], reg_rdata_out[5:0]} ==
        $past({mode_r[7], mode_r[5:0]}))
        else $error("mode read mismatch");
    a_coi_off: assert property (
        $past(reg_rd_in && reg_addr_in == `ATSC_OFF_MODE && off_w) |->
        !reg_rdata_out[`ATSC_MB_COI])
        else $error("compare bit set while disabled");
    a_unmapped_zero: assert property (
        $past(reg_rd_in && reg_addr_in > `ATSC_OFF_STATUS) |->
        reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    a_irq_pulse: assert property (
        address_match_irq_out |=> !address_match_irq_out)
        else $error("interrupt longer than one cycle");
    a_irq_done: assert property (
        address_match_irq_out |-> ##[0:2] transfer_done_flag_out)
        else $error("interrupt without done flag");
    a_done_stands: assert property (
        $fell(transfer_done_flag_out) |->
        $past(clr_w) || $past(clr_w, 2) || $past(clr_w, 3))
        else $error("done flag dropped without clear");
    a_data_open: assert property (
        !bus_data_a_out && !bus_data_b_out)
        else $error("data line driven high");
    a_ext_clock: assert property (
        (off_w || !mode_r[`ATSC_MB_CLK_HI]) &&
        $past(off_w || !mode_r[`ATSC_MB_CLK_HI]) |-> bus_clock_pin_oe_n_out)
        else $error("clock driven in external mode");
    a_off_quiet: assert property (
        off_w && $past(off_w) && $past(off_w, 2) |->
        bus_data_a_oe_n_out && bus_data_b_oe_n_out)
        else $error("data pulled low while stopped");
endmodule // atsc_props

bind atsc_top atsc_props atsc_props_i (.sys_clk_in, .rst_in,
    .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
    .bus_clock_pin_oe_n_out, .bus_data_a_out, .bus_data_a_oe_n_out,
    .bus_data_b_out, .bus_data_b_oe_n_out, .transfer_done_flag_out,
    .address_match_irq_out);

// >>> testbench/tb.sv
/*
 * Bench of the serial channel top: register tasks, tick sources and
 * a far-end model on the shared lines.
 * Assumes pull-ups on both data lines and an idle-high clock line.
 */
`timescale 1ns/1ps
`include "atsc_consts.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end

module tb;
    logic clk = 0, rst = 1, wr = 0, rd = 0, t2 = 0, t3 = 0, sel_a = 1;
    logic [2:0] addr = 0;
    logic [7:0] wd = 0;
    logic [3:0] tcnt = 0;
    wire [7:0] rdata;
    wire ck_oe_n, ck_o, a_o, a_oe_n, b_o, b_oe_n, done, irq, fsck, flow;
    int errors = 0, compares = 0, irqs = 0;
    // Wired lines: clock muxed by enable, data wired-AND with pull-up
    wire sck_line = ck_oe_n ? fsck : ck_o;
    wire line_a = (a_oe_n | a_o) & !flow;
    wire line_b = (b_oe_n | b_o) & !flow;

    // 25 MHz system clock
    always #20 clk = ~clk;
    // Two tick sources at unlike rates, so a wrong select shows
    always @(posedge clk)
    begin
        tcnt <= tcnt + 4'h1;
        t2 <= tcnt[1:0] == 2'h0;
        t3 <= tcnt[2:0] == 3'h3;
    end
    // Interrupt pulses counted as they come
    always @(posedge clk)
        if (irq === 1'b1) irqs++;

    atsc_top atsc_top_i (.sys_clk_in(clk), .rst_in(rst),
        .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata), .timer2_tick_in(t2),
        .timer_clk_sel3_tick_in(t3), .bus_clock_pin_in(sck_line),
        .bus_clock_pin_out(ck_o), .bus_clock_pin_oe_n_out(ck_oe_n),
        .bus_data_a_in(line_a), .bus_data_a_out(a_o),
        .bus_data_a_oe_n_out(a_oe_n), .bus_data_b_in(line_b),
        .bus_data_b_out(b_o), .bus_data_b_oe_n_out(b_oe_n),
        .transfer_done_flag_out(done), .address_match_irq_out(irq));
    atsc_far_end atsc_far_end_i (.sck_in(sck_line),
        .sda_in(sel_a ? line_a : line_b), .sck_out(fsck),
        .sda_low_out(flow));

    task finish_test;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task rd_chk(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        `CHK(rdata, e)
    endtask
    task wait_done;
        int n;
        n = 0;
        while (done !== 1'b1 && n < 3000)
        begin
            @(posedge clk);
            n++;
        end
        if (n == 3000)
        begin
            errors++;
            $display("[ERR] %0t no done flag", $time);
            finish_test();
        end
        repeat (4) @(posedge clk);
    endtask
    // Fresh counters, old done cleared, then the new mode
    task start_frame(input logic [7:0] m);
        atsc_far_end_i.rises = 0;
        atsc_far_end_i.falls = 0;
        irqs = 0;
        wr_reg(`ATSC_OFF_STATUS, 8'h01);
        wr_reg(`ATSC_OFF_MODE, m);
    endtask

    task t_regs;
        rd_chk(`ATSC_OFF_MODE, 8'h00);
        rd_chk(`ATSC_OFF_SHIFT, 8'hff);
        rd_chk(`ATSC_OFF_SVA, 8'h00);
        rd_chk(3'h5, 8'h00);
        wr_reg(`ATSC_OFF_MODE, 8'hdf);
        rd_chk(`ATSC_OFF_MODE, 8'h9f);
        $display("test regs done");
    endtask
    task t_no_start;
        int f;
        f = 0;
        wr_reg(`ATSC_OFF_MODE, 8'h1e);
        wr_reg(`ATSC_OFF_SHIFT, 8'h5a);
        wr_reg(`ATSC_OFF_MODE, 8'h9e);
        repeat (80)
        begin
            @(posedge clk);
            if (ck_o !== 1'b1) f++;
        end
        `CHK(f, 0)
        `CHK(done, 1'b0)
        rd_chk(`ATSC_OFF_SHIFT, 8'h5a);
        $display("test no_start done");
    endtask
    task t_tx;
        sel_a = 1'b1;
        start_frame(8'h9e);
        wr_reg(`ATSC_OFF_BUSCTL, 8'h01);
        wr_reg(`ATSC_OFF_SHIFT, 8'ha5);
        wait_done();
        `CHK(atsc_far_end_i.rx_byte, 8'ha5)
        `CHK(atsc_far_end_i.rises, 8)
        `CHK(irqs, 1)
        rd_chk(`ATSC_OFF_STATUS, 8'h01);
        rd_chk(`ATSC_OFF_SHIFT, 8'ha5);
        wr_reg(`ATSC_OFF_STATUS, 8'h01);
        rd_chk(`ATSC_OFF_STATUS, 8'h00);
        $display("test tx done");
    endtask
    task t_rx_ext;
        sel_a = 1'b0;
        start_frame(8'h98);
        wr_reg(`ATSC_OFF_SHIFT, 8'hff);
        atsc_far_end_i.tx_byte = 8'h3c;
        atsc_far_end_i.gen_clock(8);
        wait_done();
        atsc_far_end_i.tx_byte = 8'hff;
        rd_chk(`ATSC_OFF_SHIFT, 8'h3c);
        wr_reg(`ATSC_OFF_SVA, 8'h3c);
        rd_chk(`ATSC_OFF_MODE, 8'hd8);
        wr_reg(`ATSC_OFF_STATUS, 8'h01);
        wr_reg(`ATSC_OFF_MODE, 8'h18);
        rd_chk(`ATSC_OFF_MODE, 8'h18);
        $display("test rx_ext done");
    endtask
    task t_sbi;
        sel_a = 1'b1;
        start_frame(8'h97);
        wr_reg(`ATSC_OFF_SHIFT, 8'h81);
        wait_done();
        `CHK(atsc_far_end_i.rises, 9)
        `CHK(line_a, 1'b1)
        `CHK(irqs, 1)
        rd_chk(`ATSC_OFF_STATUS, 8'h01);
        wr_reg(`ATSC_OFF_STATUS, 8'h01);
        wr_reg(`ATSC_OFF_MODE, 8'h00);
        $display("test sbi done");
    endtask
    // Wake-up with no release seen: the address is never taken
    task t_wake;
        sel_a = 1'b1;
        start_frame(8'h97);
        wr_reg(`ATSC_OFF_BUSCTL, 8'h00);
        repeat (4) @(posedge clk);
        `CHK(line_a, 1'b1)
        wr_reg(`ATSC_OFF_MODE, 8'hb7);
        wr_reg(`ATSC_OFF_SHIFT, 8'h00);
        repeat (200) @(posedge clk);
        `CHK(atsc_far_end_i.rises, 9)
        `CHK(atsc_far_end_i.rx_byte, 8'hff)
        `CHK(irqs, 0)
        rd_chk(`ATSC_OFF_STATUS, 8'h00);
        wr_reg(`ATSC_OFF_MODE, 8'h00);
        $display("test wake done");
    endtask

    // Reset for two cycles, then the scenarios in turn
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_no_start();
        t_tx();
        t_rx_ext();
        t_sbi();
        t_wake();
        finish_test();
    end
endmodule // tb
